// ===== rtl/dagu_pkg.sv
// Contract
// - low base half ignores page registers
// - upper half with page zero traps
// - both page registers reset to one
// - writing zero leaves page unchanged
// - page selects consecutive 32 KB regions
// - nonzero pages only via base bit 15
// - file register address is 13 bits
// - operand one direct, two register or literal
// - post-modify uses old pointer value
// - pre-modify uses changed pointer value
// - indexed adds pointer and second register
// - literal offset adds pointer and literal
// - modulo correction for any working register
// - boundary check triggers beyond bounds too
// - writeback only for pre/post modify
// - bit reversal only primary unit writes
// - only modifier is bit reversed; code also reverses pointer and the sum
// - reversal enabled by modifier bit 15
// - reversal only pre/post increment word writes
package dagu_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PAGE_W = 10;
  localparam int unsigned EXT_W = 24;
  localparam int unsigned NUM_W = 16;
  localparam int unsigned FILE_W = 13;
  localparam int unsigned LIT_W = 5;
  localparam logic [9:0] PAGE_RESET = 10'h001;
  localparam logic [9:0] PAGE_ZERO = 10'h000;
  localparam int unsigned EA_HI_BIT = 15;
  localparam int unsigned BITREV_ENABLE_BIT = 15;
  localparam int unsigned NEAR_LIMIT = 8192;
  typedef enum logic [6:0] {
    DAGU_MODE_DIRECT = 7'h01,
    DAGU_MODE_IND = 7'h02,
    DAGU_MODE_POST = 7'h04,
    DAGU_MODE_PRE = 7'h08,
    DAGU_MODE_REGIDX = 7'h10,
    DAGU_MODE_LITOFS = 7'h20,
    DAGU_MODE_FILE = 7'h40
  } dagu_mode_t;
  function automatic logic [15:0] dagu_rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction
endpackage

// ===== rtl/dagu_modulo.sv
`timescale 1ns/1ns
module dagu_modulo
(
  // address in
  input wire logic [15:0] addr_i,
  input wire logic incr_i,
  input wire logic enable_i,
  // bounds
  input wire logic [15:0] start_i,
  input wire logic [15:0] end_i,
  // corrected
  output logic [15:0] addr_o,
  output logic wrap_o
);
  wire over_hi = incr_i && (addr_i > end_i);
  wire under_lo = !incr_i && (addr_i < start_i);
  wire [15:0] span = 16'(end_i - start_i + 16'h0001);
  assign wrap_o = enable_i && (over_hi || under_lo);
  assign addr_o = !wrap_o ? addr_i : (over_hi ? 16'(addr_i - span) : 16'(addr_i + span));
endmodule // dagu_modulo

// ===== rtl/dagu_ext_map.sv
`timescale 1ns/1ns
module dagu_ext_map
(
  // base address and page
  input wire logic [15:0] ea_i,
  input wire logic [9:0] page_i,
  // extended address
  output logic [23:0] ext_o,
  output logic page_err_o
);
  wire upper = ea_i[dagu_pkg::EA_HI_BIT];
  // lower half ignores paging entirely
  assign ext_o = upper ? {page_i[8:0], ea_i[14:0]} : {8'h00, ea_i};
  assign page_err_o = upper && (page_i == dagu_pkg::PAGE_ZERO);
endmodule // dagu_ext_map

// ===== rtl/dagu_top.sv
`timescale 1ns/1ns
module dagu_top
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // page register writes
  input wire logic page_rd_we_i,
  input wire logic page_wr_we_i,
  input wire logic [9:0] page_wdata_i,
  // modulo setup
  input wire logic mod_en_i,
  input wire logic [3:0] mod_reg_i,
  input wire logic mod_incr_i,
  input wire logic [15:0] mod_start_i,
  input wire logic [15:0] mod_end_i,
  // reversal modifier register
  input wire logic rev_we_i,
  input wire logic [15:0] rev_wdata_i,
  // request from decode
  input wire logic req_i,
  input wire dagu_pkg::dagu_mode_t mode_i,
  input wire logic is_write_i,
  input wire logic is_byte_i,
  input wire logic primary_i,
  input wire logic [3:0] ptr_sel_i,
  input wire logic [15:0] ptr_val_i,
  input wire logic [15:0] idx_val_i,
  input wire logic [15:0] mod_const_i,
  input wire logic [12:0] file_addr_i,
  input wire logic [15:0] base_val_i,
  input wire logic op2_lit_i,
  input wire logic [4:0] op2_lit_val_i,
  input wire logic [15:0] op2_reg_i,
  // results
  output logic valid_o,
  output logic [23:0] ext_addr_o,
  output logic [15:0] ea_o,
  output logic wb_en_o,
  output logic [3:0] wb_sel_o,
  output logic [15:0] wb_val_o,
  output logic [15:0] op1_o,
  output logic [15:0] op2_o,
  output logic addr_err_o,
  output logic [9:0] page_rd_o,
  output logic [9:0] page_wr_o,
  output logic [15:0] rev_mod_o
);
  logic [9:0] page_rd;
  logic [9:0] page_wr;
  logic [15:0] rev_mod;

  // page registers: a zero write is dropped so page 0 stays unreachable via upper half
  wire rd_take = page_rd_we_i && (page_wdata_i != dagu_pkg::PAGE_ZERO);
  wire wr_take = page_wr_we_i && (page_wdata_i != dagu_pkg::PAGE_ZERO);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      page_rd <= dagu_pkg::PAGE_RESET;
      page_wr <= dagu_pkg::PAGE_RESET;
      rev_mod <= 16'h0000;
    end
    else
    begin
      if (rd_take)
        page_rd <= page_wdata_i;
      if (wr_take)
        page_wr <= page_wdata_i;
      if (rev_we_i)
        rev_mod <= rev_wdata_i;
    end
  end

  // address modes
  wire is_post = (mode_i == dagu_pkg::DAGU_MODE_POST);
  wire is_pre = (mode_i == dagu_pkg::DAGU_MODE_PRE);
  wire is_file = (mode_i == dagu_pkg::DAGU_MODE_FILE);
  wire is_regidx = (mode_i == dagu_pkg::DAGU_MODE_REGIDX);
  wire is_litofs = (mode_i == dagu_pkg::DAGU_MODE_LITOFS);
  wire is_ind = (mode_i == dagu_pkg::DAGU_MODE_IND);
  wire incr = !mod_const_i[15];

  // reversal: pointer and modifier are both reversed, added, and the sum reversed back
  wire rev_on = rev_mod[dagu_pkg::BITREV_ENABLE_BIT] && primary_i && is_write_i && !is_byte_i
    && incr && (is_pre || is_post);
  wire [15:0] rev_sum = 16'(dagu_pkg::dagu_rev16(dagu_pkg::dagu_rev16(ptr_val_i)
    + dagu_pkg::dagu_rev16({rev_mod[14:0], 1'b0}))) & 16'hfffe;

  wire [15:0] modified = 16'(ptr_val_i + mod_const_i);
  wire [15:0] ofs_sum = is_regidx ? 16'(ptr_val_i + idx_val_i)
    : 16'(ptr_val_i + {{11{op2_lit_val_i[4]}}, op2_lit_val_i});

  // raw address before modulo; post-modify presents old pointer value
  wire [15:0] raw_ea = is_file ? {3'h0, file_addr_i}
    : is_pre ? modified
    : (is_post || is_ind) ? ptr_val_i
    : ofs_sum;
  // the updated pointer value for writeback
  wire [15:0] raw_upd = is_pre ? modified : 16'(ptr_val_i + mod_const_i);

  // modulo applies to whichever register the setup names
  wire mod_hit = mod_en_i && (mod_reg_i == ptr_sel_i) && !is_file && !rev_on;
  wire [15:0] corr_ea;
  wire [15:0] corr_upd;
  wire wrap_ea;

  dagu_modulo u_mod_ea
  (
    .addr_i(raw_ea),
    .incr_i(incr),
    .enable_i(mod_hit),
    .start_i(mod_start_i),
    .end_i(mod_end_i),
    .addr_o(corr_ea),
    .wrap_o(wrap_ea)
  );

  dagu_modulo u_mod_upd
  (
    .addr_i(raw_upd),
    .incr_i(incr),
    .enable_i(mod_hit),
    .start_i(mod_start_i),
    .end_i(mod_end_i),
    .addr_o(corr_upd),
    .wrap_o()
  );

  wire [15:0] final_ea = rev_on ? (is_pre ? rev_sum : ptr_val_i) : corr_ea;
  wire [15:0] final_upd = rev_on ? rev_sum : corr_upd;
  // offset modes correct the address but never touch the pointer
  wire do_wb = (is_pre || is_post);

  wire [9:0] page_sel = is_write_i ? page_wr : page_rd;
  wire [23:0] ext_addr;
  wire page_err;

  dagu_ext_map u_map
  (
    .ea_i(final_ea),
    .page_i(page_sel),
    .ext_o(ext_addr),
    .page_err_o(page_err)
  );

  // operand one always direct, operand two register or literal
  wire [15:0] op2 = op2_lit_i ? {11'h000, op2_lit_val_i} : op2_reg_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      valid_o <= 1'b0;
      ext_addr_o <= 24'h000000;
      ea_o <= 16'h0000;
      wb_en_o <= 1'b0;
      wb_sel_o <= 4'h0;
      wb_val_o <= 16'h0000;
      op1_o <= 16'h0000;
      op2_o <= 16'h0000;
      addr_err_o <= 1'b0;
    end
    else
    begin
      valid_o <= req_i && !page_err;
      ext_addr_o <= ext_addr;
      ea_o <= final_ea;
      wb_en_o <= req_i && do_wb;
      wb_sel_o <= ptr_sel_i;
      wb_val_o <= final_upd;
      op1_o <= base_val_i;
      op2_o <= op2;
      addr_err_o <= req_i && page_err && !is_file;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      page_rd_o <= dagu_pkg::PAGE_RESET;
      page_wr_o <= dagu_pkg::PAGE_RESET;
      rev_mod_o <= 16'h0000;
    end
    else
    begin
      page_rd_o <= page_rd;
      page_wr_o <= page_wr;
      rev_mod_o <= rev_mod;
    end
  end

  a_page_reset_one: assert property (@(posedge sys_clk_i) $fell(rst_i) |-> page_rd == 10'h001 && page_wr == 10'h001)
    else $error("page registers not one after reset");
  a_page_zero_kept: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    page_rd_we_i && page_wdata_i == 10'h000 |=> page_rd == $past(page_rd))
    else $error("zero write changed read page");
  a_low_half_flat: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && !final_ea[15] |=> ext_addr_o == {8'h00, ea_o})
    else $error("lower half address paged");
  a_upper_page_map: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && final_ea[15] && !page_err |=> ext_addr_o == {$past(page_sel[8:0]), ea_o[14:0]})
    else $error("upper half mapping wrong");
  a_page_zero_trap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && !is_file && final_ea[15] && page_sel == 10'h000 |=> addr_err_o && !valid_o)
    else $error("page zero access not trapped");
  a_offset_no_wb: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && (is_regidx || is_litofs) |=> !wb_en_o)
    else $error("offset mode wrote pointer back");
  a_post_old_ptr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && is_post && !mod_hit && !rev_on |=> ea_o == $past(ptr_val_i))
    else $error("post modify used changed pointer");
  a_file_near: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    req_i && is_file |=> ea_o < 16'h2000)
    else $error("file address beyond near space");
  a_byte_no_rev: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    is_byte_i || !is_write_i |-> !rev_on)
    else $error("reversal on byte or read access");
endmodule // dagu_top

// ===== sim/dagu_dec_model.sv
`timescale 1ns/1ns
module dagu_dec_model
(
  // clock
  input wire logic sys_clk_i,
  // request towards the address unit
  output logic req_o,
  output dagu_pkg::dagu_mode_t mode_o,
  output logic is_write_o,
  output logic is_byte_o,
  output logic [15:0] ptr_val_o,
  output logic [15:0] idx_val_o,
  output logic [15:0] mod_const_o,
  output logic [12:0] file_addr_o,
  output logic [15:0] base_val_o,
  output logic op2_lit_o,
  output logic [4:0] op2_lit_val_o,
  output logic [15:0] op2_reg_o
);
  initial
  begin
    mode_o = dagu_pkg::DAGU_MODE_DIRECT;
    {req_o, is_write_o, is_byte_o, ptr_val_o, idx_val_o, mod_const_o} = '0;
    {file_addr_o, base_val_o, op2_lit_o, op2_lit_val_o, op2_reg_o} = '0;
  end
  // requests may follow every cycle, so req_o is lowered only by idle
  task automatic issue(input dagu_pkg::dagu_mode_t m, input logic w, b,
    input logic [15:0] p, x, k, input logic [12:0] f, input logic [15:0] bv,
    input logic l, input logic [4:0] lv, input logic [15:0] r);
    @(posedge sys_clk_i);
    {req_o, is_write_o, is_byte_o, ptr_val_o, idx_val_o, mod_const_o} <= {1'b1, w, b, p, x, k};
    {file_addr_o, base_val_o, op2_lit_o, op2_lit_val_o, op2_reg_o} <= {f, bv, l, lv, r};
    mode_o <= m;
  endtask
  task automatic idle();
    @(posedge sys_clk_i);
    req_o <= 1'b0;
  endtask
endmodule // dagu_dec_model

// ===== sim/dagu_top_tb_top.sv
`timescale 1ns/1ns
module dagu_top_tb_top;
  logic sys_clk_i, rst_i, page_rd_we_i, page_wr_we_i, mod_en_i, mod_incr_i, rev_we_i, primary_i;
  logic [9:0] page_wdata_i, page_rd_o, page_wr_o, prd, pwr;
  logic [15:0] rev_wdata_i, ea_o, wb_val_o, op1_o, op2_o, rev_mod_o;
  logic req_i, is_write_i, is_byte_i, op2_lit_i, valid_o, wb_en_o, addr_err_o;
  logic [15:0] ptr_val_i, idx_val_i, mod_const_i, base_val_i, op2_reg_i, pv, kv;
  logic [12:0] file_addr_i;
  logic [4:0] op2_lit_val_i;
  logic [23:0] ext_addr_o;
  logic [3:0] wb_sel_o;
  dagu_pkg::dagu_mode_t mode_i;
  dagu_pkg::dagu_mode_t mt [4];
  logic [89:0] notes [$];
  int seed, error_cnt, comparisons;
  dagu_top u_dagu_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .page_rd_we_i(page_rd_we_i),
    .page_wr_we_i(page_wr_we_i), .page_wdata_i(page_wdata_i), .mod_en_i(mod_en_i),
    .mod_reg_i(4'h2), .mod_incr_i(mod_incr_i), .mod_start_i(16'h1000), .mod_end_i(16'h100f),
    .rev_we_i(rev_we_i), .rev_wdata_i(rev_wdata_i), .req_i(req_i), .mode_i(mode_i),
    .is_write_i(is_write_i), .is_byte_i(is_byte_i), .primary_i(primary_i), .ptr_sel_i(4'h2),
    .ptr_val_i(ptr_val_i), .idx_val_i(idx_val_i), .mod_const_i(mod_const_i),
    .file_addr_i(file_addr_i), .base_val_i(base_val_i), .op2_lit_i(op2_lit_i),
    .op2_lit_val_i(op2_lit_val_i), .op2_reg_i(op2_reg_i), .valid_o(valid_o),
    .ext_addr_o(ext_addr_o), .ea_o(ea_o), .wb_en_o(wb_en_o), .wb_sel_o(wb_sel_o),
    .wb_val_o(wb_val_o), .op1_o(op1_o), .op2_o(op2_o), .addr_err_o(addr_err_o),
    .page_rd_o(page_rd_o), .page_wr_o(page_wr_o), .rev_mod_o(rev_mod_o));
  dagu_dec_model u_dagu_dec_model (.sys_clk_i(sys_clk_i), .req_o(req_i), .mode_o(mode_i),
    .is_write_o(is_write_i), .is_byte_o(is_byte_i), .ptr_val_o(ptr_val_i),
    .idx_val_o(idx_val_i), .mod_const_o(mod_const_i), .file_addr_o(file_addr_i),
    .base_val_o(base_val_i), .op2_lit_o(op2_lit_i), .op2_lit_val_o(op2_lit_val_i),
    .op2_reg_o(op2_reg_i));
  task automatic check(input logic [89:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // wbx is the expected writeback, also the pre-modify address
  task automatic go(input dagu_pkg::dagu_mode_t m, input logic w, b, input logic [15:0] p, k, wbx);
    logic [15:0] x, bv, r, ea;
    logic [12:0] f;
    logic [9:0] pg;
    logic [4:0] lv;
    logic l, we;
    x = $random(seed);
    bv = $random(seed);
    r = $random(seed);
    f = $random(seed);
    lv = $random(seed);
    l = $random(seed);
    ea = p;
    we = (m == dagu_pkg::DAGU_MODE_POST || m == dagu_pkg::DAGU_MODE_PRE);
    if (m == dagu_pkg::DAGU_MODE_PRE) ea = wbx;
    if (m == dagu_pkg::DAGU_MODE_REGIDX) ea = p + x;
    if (m == dagu_pkg::DAGU_MODE_FILE) ea = {3'h0, f};
    pg = w ? pwr : prd;
    notes.push_back({1'b0, ea[15] ? {pg[8:0], ea[14:0]} : {8'h00, ea}, ea, we,
      we ? wbx : 16'h0000, bv, l ? {11'h000, lv} : r});
    u_dagu_dec_model.issue(m, w, b, p, x, k, f, bv, l, lv, r);
  endtask
  always @(negedge sys_clk_i)
    if (valid_o === 1'b1 || addr_err_o === 1'b1)
      check({addr_err_o, ext_addr_o, ea_o, wb_en_o, wb_en_o ? wb_val_o : 16'h0000, op1_o,
        op2_o}, notes.pop_front());
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #20000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    seed = 48;
    mt = '{dagu_pkg::DAGU_MODE_POST, dagu_pkg::DAGU_MODE_PRE, dagu_pkg::DAGU_MODE_REGIDX,
      dagu_pkg::DAGU_MODE_FILE};
    {rst_i, primary_i} = 2'b11;
    {page_rd_we_i, page_wr_we_i, page_wdata_i, mod_en_i, mod_incr_i, rev_we_i, rev_wdata_i} = '0;
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(negedge sys_clk_i);
    check({page_rd_o, page_wr_o}, {10'h001, 10'h001});
    @(posedge sys_clk_i);
    {page_rd_we_i, page_wr_we_i, page_wdata_i} <= {2'b11, 10'h000};
    @(posedge sys_clk_i);
    {page_rd_we_i, page_wr_we_i, page_wdata_i} <= {2'b10, 10'h002};
    @(posedge sys_clk_i);
    {page_rd_we_i, page_wr_we_i, page_wdata_i} <= {2'b01, 10'h003};
    @(negedge sys_clk_i);
    check(page_wr_o, 10'h001);
    @(posedge sys_clk_i);
    {page_rd_we_i, page_wr_we_i} <= 2'b00;
    repeat (2) @(negedge sys_clk_i);
    check({page_rd_o, page_wr_o}, {10'h002, 10'h003});
    {prd, pwr} = {10'h002, 10'h003};
    go(dagu_pkg::DAGU_MODE_POST, 1'b0, 1'b0, 16'h1000, 16'h0002, 16'h1002);
    go(dagu_pkg::DAGU_MODE_PRE, 1'b1, 1'b0, 16'h9000, 16'hfffe, 16'h8ffe);
    for (int i = 0; i < 24; i++)
    begin
      pv = $random(seed);
      kv = $random(seed);
      go(mt[i % 4], i[0], i[1], pv, kv, 16'(pv + kv));
    end
    u_dagu_dec_model.idle();
    {mod_en_i, mod_incr_i} <= 2'b11;
    go(dagu_pkg::DAGU_MODE_POST, 1'b0, 1'b0, 16'h100e, 16'h0004, 16'h1002);
    go(dagu_pkg::DAGU_MODE_PRE, 1'b0, 1'b0, 16'h1002, 16'hfffc, 16'h100e);
    u_dagu_dec_model.idle();
    {mod_en_i, rev_we_i, rev_wdata_i} <= {2'b01, 16'h8008};
    @(posedge sys_clk_i);
    rev_we_i <= 1'b0;
    u_dagu_dec_model.idle();
    go(dagu_pkg::DAGU_MODE_POST, 1'b1, 1'b0, 16'h0010, 16'h0002, 16'h0008);
    go(dagu_pkg::DAGU_MODE_POST, 1'b1, 1'b1, 16'h0010, 16'h0002, 16'h0012);
    go(dagu_pkg::DAGU_MODE_POST, 1'b0, 1'b0, 16'h0010, 16'h0002, 16'h0012);
    u_dagu_dec_model.idle();
    primary_i <= 1'b0;
    go(dagu_pkg::DAGU_MODE_POST, 1'b1, 1'b0, 16'h0010, 16'h0002, 16'h0012);
    u_dagu_dec_model.idle();
    primary_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    check(rev_mod_o, 16'h8008);
    // every noted request must have been answered
    check(notes.size(), 0);
    give_verdict();
  end
endmodule // dagu_top_tb_top
